// file: dv/smbus_far_end.sv
// Purpose: Far-end SMBus device driving the serial clock and data lines.
// Assumes: Open-drain lines with pull-ups, so a released line reads high.
// Notes: Only the levels that START and STOP need are modelled.
`timescale 1ns/1ps
module smbus_far_end (
    input wire logic clk_i,
    output logic scl_o,
    output logic sda_o
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic lines(input logic s, input logic d, input int n);
        @(posedge clk_i);
        scl_o <= s;
        sda_o <= d;
        repeat (n) @(posedge clk_i);
    endtask
    task automatic start_c;
        lines(1'b1, 1'b0, 4);
        lines(1'b0, 1'b0, 4);
    endtask
    // The clock goes low alone first, so no false START is made.
    task automatic stop_c;
        lines(1'b0, 1'b1, 4);
        lines(1'b0, 1'b0, 4);
        lines(1'b1, 1'b0, 4);
        // One edge more than elsewhere, so the stop flag has landed when this returns.
        lines(1'b1, 1'b1, 5);
    endtask
endmodule

// file: dv/smbus_flags_chk_assertions.sv
// Purpose: Port assertions for the SMBus status flag block.
// Assumes: One clock; lines reach the flag logic through three flops.
// Notes: The line history stands in for the synchroniser delay.
`timescale 1ns/1ps
module smbus_flags_chk
    import smbus_flags_pkg::*;
(
    input wire logic CORE_CLK_I,
    input wire logic RST_N_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [APB_ADDR_W-1:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [3:0] PSTRB_I,
    input wire logic PREADY_O,
    input wire logic SDA_I,
    input wire engine_ev_t ENGINE_I,
    input wire flags_t FLAGS_O,
    input wire logic HW_ACK_EN_O
);
    logic [2:0] sda_hist;
    logic sda_lo;
    logic sda_hi;
    logic w1c;
    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (!RST_N_I);
    ////////////////////////////////////////////////////////////////////////////////
    // A line is judged only when steady for three samples, since the sampling moment is fuzzy.
    // The window ends three edges back, where the synchroniser and detector put the flag input.
    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            sda_hist <= 3'h7;
        end else begin
            sda_hist <= {sda_hist[1:0], SDA_I};
        end
    end
    assign sda_lo = (sda_hist == 3'h0);
    assign sda_hi = (sda_hist == 3'h7);
    assign w1c = PSEL_I && PENABLE_I && PWRITE_I && PREADY_O && PSTRB_I[0]
        && (PADDR_I == STATUS_OFFSET) && PWDATA_I[ST_PORT_INT_BIT];
    ////////////////////////////////////////////////////////////////////////////////
    chk_ack_req_set: assert property (
        ENGINE_I.byte_received && !HW_ACK_EN_O |=> FLAGS_O.ack_request_flag)
        else $error("ack request flag not set");
    chk_ack_req_end: assert property (
        ENGINE_I.ack_end && !(ENGINE_I.byte_received && !HW_ACK_EN_O)
        |=> !FLAGS_O.ack_request_flag) else $error("ack request flag not cleared");
    chk_int_rx: assert property (
        ENGINE_I.byte_received |=> FLAGS_O.port_interrupt_flag)
        else $error("interrupt flag missed a received byte");
    chk_int_tx: assert property (
        ENGINE_I.byte_sent_acked |=> FLAGS_O.port_interrupt_flag)
        else $error("interrupt flag missed a sent byte");
    chk_int_start: assert property (
        ENGINE_I.start_generated |=> FLAGS_O.port_interrupt_flag)
        else $error("interrupt flag missed a start");
    chk_arb_int: assert property (
        $rose(FLAGS_O.arbitration_lost_flag) |-> FLAGS_O.port_interrupt_flag)
        else $error("arbitration loss without interrupt");
    chk_int_sticky: assert property (
        FLAGS_O.port_interrupt_flag && !w1c |=> FLAGS_O.port_interrupt_flag)
        else $error("interrupt flag cleared by hardware");
    chk_arb_data: assert property (
        ENGINE_I.bit_sample && ENGINE_I.tx_one && !ENGINE_I.ack_phase && sda_lo
        |=> FLAGS_O.arbitration_lost_flag) else $error("data low sending one missed");
    chk_ack_low: assert property (
        ENGINE_I.ack_sample && sda_lo |=> FLAGS_O.ack_value_flag)
        else $error("ack value flag not set");
    chk_ack_high: assert property (
        ENGINE_I.ack_sample && sda_hi |=> !FLAGS_O.ack_value_flag)
        else $error("ack value flag not cleared");
    chk_reset_flags: assert property (
        disable iff (1'b0) !RST_N_I |=> FLAGS_O == STATUS_RESET)
        else $error("flags not cleared by reset");
endmodule
bind smbus_status_flags smbus_flags_chk i_smbus_flags_chk (
    .CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PSTRB_I(PSTRB_I),
    .PREADY_O(PREADY_O), .SDA_I(SDA_I), .ENGINE_I(ENGINE_I), .FLAGS_O(FLAGS_O),
    .HW_ACK_EN_O(HW_ACK_EN_O));

// file: dv/smbus_status_flag_logic_bench.sv
// Purpose: Self-checking bench for the SMBus status flag block.
// Assumes: Lines come from the far-end model, engine events from here.
// Notes: Engine pulses are set by bit index of the packed event struct.
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fail_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module smbus_status_flag_logic_bench
    import smbus_flags_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [7:0] pa = 8'h00;
    logic [31:0] pwd = 32'h0;
    logic [31:0] prd;
    logic rdy;
    logic err;
    logic scl;
    logic sda;
    logic hwack;
    logic sreq;
    logic aout;
    engine_ev_t ev = '0;
    flags_t fl;
    logic [31:0] r;
    logic e;
    int fail_count = 0;
    int n_tests = 0;
    always #25 clk = ~clk;
    smbus_far_end i_smbus_far_end (.clk_i(clk), .scl_o(scl), .sda_o(sda));
    smbus_status_flags i_smbus_status_flags (
        .CORE_CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
        .PADDR_I(pa), .PWDATA_I(pwd), .PSTRB_I(4'hF), .PRDATA_O(prd), .PREADY_O(rdy),
        .PSLVERR_O(err), .SCL_I(scl), .SDA_I(sda), .ENGINE_I(ev), .FLAGS_O(fl),
        .HW_ACK_EN_O(hwack), .START_REQ_O(sreq), .ACK_OUT_O(aout));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (rdy !== 1'b1);
        r = prd;
        e = err;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    // The extra edge lets the write land before flags are looked at.
    task automatic clr;
        apb(1'b1, STATUS_OFFSET, 32'h3F);
        @(posedge clk);
    endtask
    task automatic pu(input int b);
        @(posedge clk);
        ev[b] <= 1'b1;
        @(posedge clk);
        ev[b] <= 1'b0;
        @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        `CHK(fl, STATUS_RESET)
        apb(1'b0, STATUS_OFFSET, 32'h0);
        `CHK(r, 32'h0)
        apb(1'b0, 8'h08, 32'h0);
        `CHK(e, 1'b1)
        apb(1'b1, CTRL_OFFSET, 32'h7);
        apb(1'b0, CTRL_OFFSET, 32'h0);
        `CHK(r, 32'h7)
        `CHK({aout, sreq, hwack}, 3'h7)
        apb(1'b1, CTRL_OFFSET, 32'h0);
    endtask
    task automatic t_ackreq;
        apb(1'b1, CTRL_OFFSET, 32'h0);
        pu(2);
        `CHK(fl.port_interrupt_flag, 1'b1)
        apb(1'b0, STATUS_OFFSET, 32'h0);
        `CHK(r, 32'h24)
        pu(4);
        `CHK(fl.ack_request_flag, 1'b0)
        clr;
        apb(1'b1, CTRL_OFFSET, 32'h1);
        pu(2);
        `CHK(fl.ack_request_flag, 1'b0)
        clr;
    endtask
    task automatic t_int;
        pu(0);
        `CHK(fl.port_interrupt_flag, 1'b1)
        repeat (20) @(posedge clk);
        `CHK(fl.port_interrupt_flag, 1'b1)
        clr;
        `CHK(fl.port_interrupt_flag, 1'b0)
        pu(1);
        `CHK(fl.port_interrupt_flag, 1'b1)
        clr;
    endtask
    task automatic t_ackval;
        i_smbus_far_end.lines(1'b0, 1'b0, 4);
        pu(5);
        `CHK(fl.ack_value_flag, 1'b1)
        i_smbus_far_end.lines(1'b0, 1'b1, 4);
        pu(5);
        `CHK(fl.ack_value_flag, 1'b0)
        i_smbus_far_end.lines(1'b1, 1'b1, 4);
    endtask
    task automatic t_stop;
        ev.slave_addressed <= 1'b1;
        i_smbus_far_end.stop_c;
        `CHK(fl.stop_flag, 1'b1)
        ev.slave_addressed <= 1'b0;
        ev.master <= 1'b1;
        ev.stop_pending <= 1'b1;
        clr;
        i_smbus_far_end.stop_c;
        `CHK(fl.stop_flag, 1'b1)
        ev.master <= 1'b0;
        ev.stop_pending <= 1'b0;
        ev.competing <= 1'b1;
        clr;
        i_smbus_far_end.stop_c;
        `CHK(fl.arbitration_lost_flag, 1'b1)
        `CHK(fl.stop_flag, 1'b0)
        ev.competing <= 1'b0;
        clr;
    endtask
    task automatic t_start;
        i_smbus_far_end.start_c;
        pu(3);
        `CHK(fl.start_flag, 1'b1)
        i_smbus_far_end.stop_c;
        clr;
        pu(3);
        `CHK(fl.start_flag, 1'b0)
    endtask
    task automatic t_arb;
        ev.master <= 1'b1;
        i_smbus_far_end.start_c;
        `CHK(fl.arbitration_lost_flag, 1'b1)
        clr;
        ev.gen_stop_rstart <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK(fl.arbitration_lost_flag, 1'b1)
        ev.gen_stop_rstart <= 1'b0;
        clr;
        ev.tx_one <= 1'b1;
        ev.ack_phase <= 1'b1;
        pu(6);
        `CHK(fl.arbitration_lost_flag, 1'b0)
        ev.ack_phase <= 1'b0;
        pu(6);
        `CHK(fl.arbitration_lost_flag, 1'b1)
        ev <= '0;
        clr;
        i_smbus_far_end.stop_c;
        ev.master <= 1'b1;
        ev.gen_rstart <= 1'b1;
        i_smbus_far_end.start_c;
        `CHK(fl.arbitration_lost_flag, 1'b0)
        ev <= '0;
        i_smbus_far_end.stop_c;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_reset;
        t_ackreq;
        t_int;
        t_ackval;
        t_stop;
        t_start;
        t_arb;
        end_of_test;
    end
    initial begin
        repeat (4000) @(posedge clk);
        fail_count++;
        end_of_test;
    end
endmodule

// file: hdl/bus_condition_detect.sv
// Purpose: Detects START and STOP conditions on synchronised lines.
// Assumes: Inputs already pass two flip-flops.
// Notes: Outputs are registered one-cycle pulses and delayed levels.
`timescale 1ns/1ps
module bus_condition_detect
    import smbus_flags_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output bus_cond_t cond_o
);

    logic prev_sda;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            prev_sda <= 1'b1;
            cond_o <= '{scl: 1'b1, sda: 1'b1, start_seen: 1'b0, stop_seen: 1'b0};
        end else begin
            prev_sda <= sda_i;
            cond_o.scl <= scl_i;
            cond_o.sda <= sda_i;
            // Data falling while the clock is high is a START, rising is a STOP.
            cond_o.start_seen <= scl_i & prev_sda & ~sda_i;
            cond_o.stop_seen <= scl_i & ~prev_sda & sda_i;
        end
    end

endmodule

// file: hdl/line_sync.sv
// Purpose: Two-stage synchroniser for the serial clock and data lines.
// Assumes: Lines are asynchronous to the core clock.
// Notes: The first stage is read only by the second.
`timescale 1ns/1ps
module line_sync
    import smbus_flags_pkg::*;
#(
    parameter int WIDTH = 2
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] stage1;

    // Reset to idle-high so no false START or STOP appears at release.
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            stage1 <= WIDTH'(LINE_IDLE);
            sync_o <= WIDTH'(LINE_IDLE);
        end else begin
            stage1 <= async_i;
            sync_o <= stage1;
        end
    end

endmodule

// file: hdl/smbus_status_flags.sv
// Purpose: Status flag set and clear logic of an SMBus port, with APB access.
// Assumes: Shift engine events arrive on the core clock; lines are async.
// Notes: Status flags other than the acknowledge value and the ack request are write-one-to-clear.
//
// Functional notes
// - Stop flag on STOP while slave addressed.
// - Stop flag when queued master STOP happens.
// - STOP while competing means arbitration lost.
// - Ack request after byte, no hardware ack.
// - Arbitration lost on unwanted repeated START.
// - Arbitration lost: clock low during STOP/restart.
// - Arbitration lost: data low sending one.
// - Ack flag set when ack bit low.
// - Interrupt on START generated or arbitration lost.
// - Interrupt after byte sent and ack sampled.
// - Interrupt after every received byte.
// - Start flag on START plus address byte.
// - Ack request cleared after ack period.
//
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/1ps
module smbus_status_flags
    import smbus_flags_pkg::*;
(
    input wire logic CORE_CLK_I,
    input wire logic RST_N_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [APB_ADDR_W-1:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [3:0] PSTRB_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic SCL_I,
    input wire logic SDA_I,
    input wire engine_ev_t ENGINE_I,
    output flags_t FLAGS_O,
    output logic HW_ACK_EN_O,
    output logic START_REQ_O,
    output logic ACK_OUT_O
);

    ////////////////////////////////////////////////////////////////////////////

    logic [1:0] lines_sync;
    bus_cond_t cond;

    // Bus lines pass two flip-flops before any detection.
    line_sync #(
        .WIDTH(2)
    ) i_line_sync (
        .clk_i(CORE_CLK_I),
        .rst_n_i(RST_N_I),
        .async_i({SCL_I, SDA_I}),
        .sync_o(lines_sync)
    );

    bus_condition_detect i_bus_condition_detect (
        .clk_i(CORE_CLK_I),
        .rst_n_i(RST_N_I),
        .scl_i(lines_sync[1]),
        .sda_i(lines_sync[0]),
        .cond_o(cond)
    );

    ////////////////////////////////////////////////////////////////////////////

    function automatic logic hit(input logic [APB_ADDR_W-1:0] addr,
                                 input logic [APB_ADDR_W-1:0] offset);
        hit = (addr == offset);
    endfunction

    logic apb_done;
    logic wr_ctrl;
    logic wr_status;
    logic [5:0] clear_mask;

    // The slave inserts one wait cycle, so every access phase is two cycles.
    assign apb_done = PSEL_I & PENABLE_I & PREADY_O;
    assign wr_ctrl = apb_done & PWRITE_I & PSTRB_I[0] & hit(PADDR_I, CTRL_OFFSET);
    assign wr_status = apb_done & PWRITE_I & PSTRB_I[0] & hit(PADDR_I, STATUS_OFFSET);
    assign clear_mask = wr_status ? PWDATA_I[5:0] : 6'h00;

    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            PREADY_O <= 1'b0;
        end else begin
            PREADY_O <= PSEL_I & PENABLE_I & ~PREADY_O;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            PRDATA_O <= 32'h0000_0000;
            PSLVERR_O <= 1'b0;
        end else if (PSEL_I & PENABLE_I & ~PREADY_O) begin
            PRDATA_O <= 32'h0000_0000;
            PSLVERR_O <= ~(hit(PADDR_I, CTRL_OFFSET) | hit(PADDR_I, STATUS_OFFSET));
            if (!PWRITE_I && hit(PADDR_I, CTRL_OFFSET)) begin
                PRDATA_O[CTRL_HW_ACK_BIT] <= HW_ACK_EN_O;
                PRDATA_O[CTRL_START_REQ_BIT] <= START_REQ_O;
                PRDATA_O[CTRL_ACK_OUT_BIT] <= ACK_OUT_O;
            end
            if (!PWRITE_I && hit(PADDR_I, STATUS_OFFSET)) begin
                PRDATA_O[ST_START_BIT] <= FLAGS_O.start_flag;
                PRDATA_O[ST_STOP_BIT] <= FLAGS_O.stop_flag;
                PRDATA_O[ST_ACK_REQ_BIT] <= FLAGS_O.ack_request_flag;
                PRDATA_O[ST_ARB_LOST_BIT] <= FLAGS_O.arbitration_lost_flag;
                PRDATA_O[ST_ACK_VALUE_BIT] <= FLAGS_O.ack_value_flag;
                PRDATA_O[ST_PORT_INT_BIT] <= FLAGS_O.port_interrupt_flag;
            end
        end else begin
            PSLVERR_O <= 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            HW_ACK_EN_O <= CTRL_RESET[CTRL_HW_ACK_BIT];
            START_REQ_O <= CTRL_RESET[CTRL_START_REQ_BIT];
            ACK_OUT_O <= CTRL_RESET[CTRL_ACK_OUT_BIT];
        end else if (wr_ctrl) begin
            HW_ACK_EN_O <= PWDATA_I[CTRL_HW_ACK_BIT];
            START_REQ_O <= PWDATA_I[CTRL_START_REQ_BIT];
            ACK_OUT_O <= PWDATA_I[CTRL_ACK_OUT_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    logic set_stop;
    logic set_arb;
    logic set_int;
    logic set_ack_req;
    logic set_start;
    logic start_armed;

    // Slave STOP, or the master's own queued STOP reaching the bus.
    assign set_stop = cond.stop_seen & ((ENGINE_I.slave_addressed & ~ENGINE_I.master)
        | (ENGINE_I.master & ENGINE_I.stop_pending));

    assign set_arb = (cond.stop_seen & ENGINE_I.competing)
        | (cond.start_seen & ENGINE_I.master & ~START_REQ_O & ~ENGINE_I.gen_rstart)
        | (ENGINE_I.gen_stop_rstart & ~cond.scl)
        | (ENGINE_I.bit_sample & ENGINE_I.tx_one & ~ENGINE_I.ack_phase & ~cond.sda);

    assign set_int = ENGINE_I.start_generated | set_arb
        | ENGINE_I.byte_sent_acked
        | ENGINE_I.byte_received;

    assign set_ack_req = ENGINE_I.byte_received & ~HW_ACK_EN_O;

    // An address byte only counts when a START opened the frame.
    assign set_start = ENGINE_I.addr_received & start_armed;

    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            start_armed <= 1'b0;
        end else if (cond.start_seen) begin
            start_armed <= 1'b1;
        end else if (ENGINE_I.addr_received | cond.stop_seen) begin
            start_armed <= 1'b0;
        end
    end

    // In every flag below a set in the same cycle as a clear wins.
    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            FLAGS_O.start_flag <= STATUS_RESET[ST_START_BIT];
        end else if (set_start) begin
            FLAGS_O.start_flag <= 1'b1;
        end else if (clear_mask[ST_START_BIT]) begin
            FLAGS_O.start_flag <= 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            FLAGS_O.stop_flag <= STATUS_RESET[ST_STOP_BIT];
        end else if (set_stop) begin
            FLAGS_O.stop_flag <= 1'b1;
        end else if (clear_mask[ST_STOP_BIT]) begin
            FLAGS_O.stop_flag <= 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            FLAGS_O.ack_request_flag <= STATUS_RESET[ST_ACK_REQ_BIT];
        end else if (set_ack_req) begin
            FLAGS_O.ack_request_flag <= 1'b1;
        end else if (ENGINE_I.ack_end) begin
            FLAGS_O.ack_request_flag <= 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            FLAGS_O.arbitration_lost_flag <= STATUS_RESET[ST_ARB_LOST_BIT];
        end else if (set_arb) begin
            FLAGS_O.arbitration_lost_flag <= 1'b1;
        end else if (clear_mask[ST_ARB_LOST_BIT]) begin
            FLAGS_O.arbitration_lost_flag <= 1'b0;
        end
    end

    // Low data in the acknowledge slot is a positive acknowledge.
    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            FLAGS_O.ack_value_flag <= STATUS_RESET[ST_ACK_VALUE_BIT];
        end else if (ENGINE_I.ack_sample) begin
            FLAGS_O.ack_value_flag <= ~cond.sda;
        end
    end

    // Hardware never clears the interrupt flag; only a status write does.
    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            FLAGS_O.port_interrupt_flag <= STATUS_RESET[ST_PORT_INT_BIT];
        end else if (set_int) begin
            FLAGS_O.port_interrupt_flag <= 1'b1;
        end else if (clear_mask[ST_PORT_INT_BIT]) begin
            FLAGS_O.port_interrupt_flag <= 1'b0;
        end
    end

endmodule

// file: inc/smbus_flags_pkg.sv
// Purpose: Shared constants and carrier types for the SMBus status flag block.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes: Offsets are byte addresses.
package smbus_flags_pkg;

    localparam int APB_ADDR_W = 8;
    localparam logic [APB_ADDR_W-1:0] CTRL_OFFSET = 8'h00;
    localparam logic [APB_ADDR_W-1:0] STATUS_OFFSET = 8'h04;

    // Control register bit positions.
    localparam int CTRL_HW_ACK_BIT = 0;
    localparam int CTRL_START_REQ_BIT = 1;
    localparam int CTRL_ACK_OUT_BIT = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;

    // Status register bit positions.
    localparam int ST_START_BIT = 0;
    localparam int ST_STOP_BIT = 1;
    localparam int ST_ACK_REQ_BIT = 2;
    localparam int ST_ARB_LOST_BIT = 3;
    localparam int ST_ACK_VALUE_BIT = 4;
    localparam int ST_PORT_INT_BIT = 5;
    localparam logic [5:0] STATUS_RESET = 6'h00;

    // Idle bus level used for synchroniser reset.
    localparam logic [1:0] LINE_IDLE = 2'h3;

    // Events and levels from the shift engine, same clock domain.
    typedef struct packed {
        logic master;
        logic slave_addressed;
        logic competing;
        logic stop_pending;
        logic gen_stop_rstart;
        logic gen_rstart;
        logic tx_one;
        logic ack_phase;
        logic bit_sample;
        logic ack_sample;
        logic ack_end;
        logic addr_received;
        logic byte_received;
        logic byte_sent_acked;
        logic start_generated;
    } engine_ev_t;

    // Bus conditions seen on the synchronised lines.
    typedef struct packed {
        logic scl;
        logic sda;
        logic start_seen;
        logic stop_seen;
    } bus_cond_t;

    typedef struct packed {
        logic start_flag;
        logic stop_flag;
        logic ack_request_flag;
        logic arbitration_lost_flag;
        logic ack_value_flag;
        logic port_interrupt_flag;
    } flags_t;

endpackage
